// ### core/supervisor_map.svh
// Constants of the supply supervisor and watchdog
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

`define CLOCK_PERIOD_NS 10
`define NS_PER_MS 1000000
`define NS_PER_US 1000
`define POWER_UP_READ_DELAY_MS 1
`define WRITE_CYCLE_MS 10
`define RESET_GLITCH_REJECT_NS 100
`define RESET_TIMEOUT_MS 200
`define THRESHOLD_TO_RESET_DELAY_US 5
`define WATCHDOG_MS 1600
`define GLITCH_CYCLES (`RESET_GLITCH_REJECT_NS / `CLOCK_PERIOD_NS)
`define RESET_DELAY_CYCLES (`THRESHOLD_TO_RESET_DELAY_US * `NS_PER_US / `CLOCK_PERIOD_NS)
`define THRESHOLD_LEVELS 3'h5
`define THRESHOLD_DEFAULT 3'h0
`define RESET_LOW_ACTIVE 1'h0
`define RESET_HIGH_ACTIVE 1'h1
// Idle pin levels {supply, write protect, data, low pin, high pin} seen by the synchronisers
`define SYNC_IDLE_LEVELS 5'h06
`define SDA_IDLE_LEVEL 1'h1

`endif

// ### core/supervisor_pkg.sv
// Types of the supply supervisor and watchdog
package supervisor_pkg;
	typedef enum logic [2:0] {
		ST_SUPPLY_LOW = 3'h1,
		ST_TIMEOUT = 3'h2,
		ST_RUN = 3'h4
	} reset_state_type;
	typedef logic [2:0] threshold_type;
endpackage

// ### core/glitch_filter.sv
// Level filter that rejects pulses no longer than a set number of cycles
`timescale 1ns/100ps
`default_nettype none
module glitch_filter #(
	parameter int unsigned STABLE = 10
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Level in and filtered level out
	input wire logic level_in,
	output logic level_out
);
	localparam int unsigned WIDTH = $clog2(STABLE + 1);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic next_level_out;

	// Output flips only after the input differs for more than STABLE cycles
	always_comb begin
		next_count = '0;
		next_level_out = level_out;
		if (level_in != level_out) begin
			if (count == WIDTH'(STABLE)) begin
				next_level_out = level_in;
			end else begin
				next_count = count + 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			level_out <= 1'b0;
		end else begin
			count <= next_count;
			level_out <= next_level_out;
		end
	end
endmodule
`default_nettype wire

// ### core/timeout_counter.sv
// Cycle counter that flags when a limit is reached
`timescale 1ns/100ps
`default_nettype none
module timeout_counter #(
	parameter int unsigned LIMIT = 1000
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Control and flag
	input wire logic clear,
	output logic done
);
	localparam int unsigned WIDTH = $clog2(LIMIT + 1);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic next_done;

	// Done rises LIMIT cycles after clear drops and holds until clear
	always_comb begin
		next_count = count;
		if (clear) begin
			next_count = '0;
		end else if (count != WIDTH'(LIMIT)) begin
			next_count = count + 1'b1;
		end
		next_done = (next_count == WIDTH'(LIMIT));
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			done <= 1'b0;
		end else begin
			count <= next_count;
			done <= next_done;
		end
	end
endmodule
`default_nettype wire

// ### core/supply_supervisor_watchdog.sv
// Reset supervisor, watchdog and write lockout of the serial memory part
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_map.svh"
module supply_supervisor_watchdog #(
	parameter int unsigned POWER_UP_READ_CYCLES =
		`POWER_UP_READ_DELAY_MS * `NS_PER_MS / `CLOCK_PERIOD_NS,
	parameter int unsigned WRITE_CYCLE_CYCLES =
		`WRITE_CYCLE_MS * `NS_PER_MS / `CLOCK_PERIOD_NS,
	parameter int unsigned RESET_TIMEOUT_CYCLES =
		`RESET_TIMEOUT_MS * `NS_PER_MS / `CLOCK_PERIOD_NS,
	parameter int unsigned WATCHDOG_CYCLES =
		`WATCHDOG_MS * `NS_PER_MS / `CLOCK_PERIOD_NS,
	parameter bit WATCHDOG_PRESENT = 1'b1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Supply comparator and threshold choice
	input wire logic supply_above_threshold,
	input wire logic threshold_program,
	input wire supervisor_pkg::threshold_type threshold_program_value,
	output var supervisor_pkg::threshold_type supply_reset_threshold,
	// Active-low reset pin
	input wire logic reset_low_in,
	output logic reset_low_out,
	output logic reset_low_oe,
	// Active-high reset pin
	input wire logic reset_high_in,
	output logic reset_high_out,
	output logic reset_high_oe,
	// Serial data line and write protect pin
	input wire logic sda_in,
	input wire logic write_protect,
	// Protocol engine side
	input wire logic write_stop,
	output logic bus_enable,
	output logic write_busy,
	output logic write_permit,
	output logic write_commit
);
	import supervisor_pkg::*;

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [4:0] sync_first;
	logic [4:0] sync_second;
	logic sda_prev;
	logic supply_s;
	logic wp_s;
	logic sda_s;
	logic low_pin_s;
	logic high_pin_s;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_first <= `SYNC_IDLE_LEVELS;
			sync_second <= `SYNC_IDLE_LEVELS;
			sda_prev <= `SDA_IDLE_LEVEL;
		end else begin
			sync_first <= {supply_above_threshold, write_protect, sda_in,
				reset_low_in, reset_high_in};
			sync_second <= sync_first;
			sda_prev <= sync_second[2];
		end
	end

	assign supply_s = sync_second[4];
	assign wp_s = sync_second[3];
	assign sda_s = sync_second[2];
	assign low_pin_s = sync_second[1];
	assign high_pin_s = sync_second[0];

	// ****************************************
	// External reset sensing
	// ****************************************
	logic reset_drive;
	logic low_sense;
	logic high_sense;
	logic low_filtered;
	logic high_filtered;
	logic external_reset;

	// Own drive masks the pins so a release never retriggers itself
	assign low_sense = (low_pin_s == `RESET_LOW_ACTIVE) && !reset_drive;
	assign high_sense = (high_pin_s == `RESET_HIGH_ACTIVE) && !reset_drive;

	glitch_filter #(.STABLE(`GLITCH_CYCLES)) low_filter (
		.clock(clock),
		.rst_n(rst_n),
		.level_in(low_sense),
		.level_out(low_filtered)
	);

	glitch_filter #(.STABLE(`GLITCH_CYCLES)) high_filter (
		.clock(clock),
		.rst_n(rst_n),
		.level_in(high_sense),
		.level_out(high_filtered)
	);

	assign external_reset = low_filtered || high_filtered;

	// ****************************************
	// Timers
	// ****************************************
	logic timeout_done;
	logic watchdog_done;
	logic watchdog_expire;
	logic power_up_done;
	logic write_done;
	logic sda_edge;
	reset_state_type state;
	reset_state_type next_state;

	assign sda_edge = sda_s ^ sda_prev;

	timeout_counter #(.LIMIT(RESET_TIMEOUT_CYCLES)) reset_timer (
		.clock(clock),
		.rst_n(rst_n),
		.clear(state != ST_TIMEOUT),
		.done(timeout_done)
	);

	timeout_counter #(.LIMIT(WATCHDOG_CYCLES)) watchdog_timer (
		.clock(clock),
		.rst_n(rst_n),
		.clear(reset_drive || sda_edge || !WATCHDOG_PRESENT),
		.done(watchdog_done)
	);

	assign watchdog_expire = watchdog_done && WATCHDOG_PRESENT;

	timeout_counter #(.LIMIT(POWER_UP_READ_CYCLES)) power_up_timer (
		.clock(clock),
		.rst_n(rst_n),
		.clear(!supply_s),
		.done(power_up_done)
	);

	timeout_counter #(.LIMIT(WRITE_CYCLE_CYCLES)) write_timer (
		.clock(clock),
		.rst_n(rst_n),
		.clear(!write_busy),
		.done(write_done)
	);

	// ****************************************
	// Reset sequencer
	// ****************************************
	logic next_reset_drive;

	always_comb begin
		next_state = state;
		case (state)
			ST_SUPPLY_LOW: begin
				if (supply_s) begin
					next_state = ST_TIMEOUT;
				end
			end
			ST_TIMEOUT: begin
				if (!supply_s) begin
					next_state = ST_SUPPLY_LOW;
				end else if (timeout_done) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!supply_s) begin
					next_state = ST_SUPPLY_LOW;
				end else if (external_reset || watchdog_expire) begin
					next_state = ST_TIMEOUT;
				end
			end
			default: begin
				next_state = ST_SUPPLY_LOW;
			end
		endcase
		next_reset_drive = (next_state != ST_RUN);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_SUPPLY_LOW;
			reset_drive <= 1'h1;
			reset_low_oe <= 1'h1;
			reset_high_oe <= 1'h1;
			reset_low_out <= `RESET_LOW_ACTIVE;
			reset_high_out <= `RESET_HIGH_ACTIVE;
		end else begin
			state <= next_state;
			reset_drive <= next_reset_drive;
			reset_low_oe <= next_reset_drive;
			reset_high_oe <= next_reset_drive;
			reset_low_out <= `RESET_LOW_ACTIVE;
			reset_high_out <= `RESET_HIGH_ACTIVE;
		end
	end

	// ****************************************
	// Write cycle and lockout
	// ****************************************
	logic next_write_busy;
	logic next_write_permit;
	logic next_write_commit;
	logic next_bus_enable;

	always_comb begin
		next_write_permit = !wp_s && supply_s;
		next_write_commit = 1'h0;
		next_write_busy = write_busy;
		if (write_busy) begin
			if (write_done) begin
				next_write_busy = 1'h0;
			end
		end else if (write_stop && write_permit) begin
			next_write_busy = 1'h1;
			next_write_commit = 1'h1;
		end
		// Slave side only answers while idle and ready
		next_bus_enable = power_up_done && !next_write_busy;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			write_busy <= 1'h0;
			write_permit <= 1'h0;
			write_commit <= 1'h0;
			bus_enable <= 1'h0;
		end else begin
			write_busy <= next_write_busy;
			write_permit <= next_write_permit;
			write_commit <= next_write_commit;
			bus_enable <= next_bus_enable;
		end
	end

	// ****************************************
	// Threshold selection
	// ****************************************
	threshold_type next_threshold;

	// Kept through supply loss, changed only by a valid program request
	always_comb begin
		next_threshold = supply_reset_threshold;
		if (threshold_program && (threshold_program_value < `THRESHOLD_LEVELS)) begin
			next_threshold = threshold_program_value;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			supply_reset_threshold <= `THRESHOLD_DEFAULT;
		end else begin
			supply_reset_threshold <= next_threshold;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	property p_supply_drop;
		$fell(supply_s) |-> ##[1:2] (reset_low_oe && reset_high_oe);
	endproperty
	a_supply_drop: assert property (p_supply_drop) else $error("late reset");

	property p_hold_low;
		(state == ST_SUPPLY_LOW) |-> (reset_low_oe && reset_high_oe);
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("reset off at low supply");

	property p_release;
		$fell(reset_low_oe) |-> ($past(timeout_done) && $past(supply_s));
	endproperty
	a_release: assert property (p_release) else $error("early release");

	property p_pins_agree;
		(reset_low_oe == reset_high_oe) && (reset_low_out == `RESET_LOW_ACTIVE);
	endproperty
	a_pins_agree: assert property (p_pins_agree) else $error("pins disagree");

	property p_glitch;
		$rose(low_filtered) |-> ($past(low_sense, 1) && $past(low_sense, 10));
	endproperty
	a_glitch: assert property (p_glitch) else $error("glitch accepted");

	property p_external;
		(state == ST_RUN) && external_reset && supply_s |=> reset_high_oe [*2];
	endproperty
	a_external: assert property (p_external) else $error("external ignored");

	property p_wdog_edge;
		sda_edge |=> !watchdog_done;
	endproperty
	a_wdog_edge: assert property (p_wdog_edge) else $error("edge not cleared");

	property p_wdog_hold;
		reset_drive |=> !watchdog_done;
	endproperty
	a_wdog_hold: assert property (p_wdog_hold) else $error("watchdog counts");

	property p_wdog_absent;
		!WATCHDOG_PRESENT |-> !watchdog_done;
	endproperty
	a_wdog_absent: assert property (p_wdog_absent) else $error("watchdog fired");

	property p_busy_bus;
		write_busy |-> !bus_enable;
	endproperty
	a_busy_bus: assert property (p_busy_bus) else $error("bus on during write");

	property p_permit;
		write_permit |-> (!$past(wp_s) && $past(supply_s));
	endproperty
	a_permit: assert property (p_permit) else $error("write not locked");

	property p_refuse;
		write_stop && !write_permit && !write_busy |=> !write_busy;
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused write ran");

	property p_write_end;
		$fell(write_busy) |-> $past(write_done);
	endproperty
	a_write_end: assert property (p_write_end) else $error("bad write length");

	property p_threshold;
		supply_reset_threshold < `THRESHOLD_LEVELS;
	endproperty
	a_threshold: assert property (p_threshold) else $error("bad threshold");

	c_write: cover property ($rose(write_busy) ##[1:1000] $fell(write_busy));
	c_watchdog: cover property (watchdog_expire ##1 reset_low_oe);
	c_external: cover property (state == ST_RUN && external_reset);
	c_power_up: cover property ($fell(reset_low_oe));
endmodule
`default_nettype wire

// ### sim/host_mcu_model.sv
// Microcontroller model: kicks the data line and may force the reset pins
`timescale 1ns/100ps
`default_nettype none
module host_mcu_model (
	// Clock
	input wire logic clock,
	// Commands from the bench
	input wire logic kick_enable,
	input wire logic force_low,
	input wire logic force_high,
	// Drive of the device on its reset pins
	input wire logic reset_low_oe,
	input wire logic reset_low_out,
	input wire logic reset_high_oe,
	input wire logic reset_high_out,
	// Wire levels
	output logic sda,
	output logic reset_low_level,
	output logic reset_high_level
);
	logic [4:0] kick_count;

	initial begin
		sda = 1'h1;
		kick_count = 5'h0;
	end
	// Master side only: toggle the data line every 32 cycles while kicking
	always @(posedge clock) begin
		kick_count <= kick_count + 5'h1;
		if (kick_enable && kick_count == 5'h0f)
			sda <= ~sda;
	end
	// Open-drain wires: pull-up on the low pin, pull-down on the high pin
	assign reset_low_level = !((reset_low_oe && !reset_low_out) || force_low);
	assign reset_high_level = (reset_high_oe && reset_high_out) || force_high;
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench of the supply supervisor and watchdog
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import supervisor_pkg::*;
	localparam int PU = 20;
	localparam int WC = 30;
	localparam int RT = 40;
	localparam int WD = 60;
	logic clock, rst_n, supply, prog, wp, stop, kick, f_low, f_high;
	threshold_type pval, thr, exp_thr;
	logic sda, low_lvl, high_lvl, low_out, low_oe, high_out, high_oe;
	logic bus_en, busy, permit, commit, nowd_oe;
	logic [15:0] seed;
	int n_fail, checked, n, i;

	supply_supervisor_watchdog #(.POWER_UP_READ_CYCLES(PU), .WRITE_CYCLE_CYCLES(WC),
		.RESET_TIMEOUT_CYCLES(RT), .WATCHDOG_CYCLES(WD), .WATCHDOG_PRESENT(1'b1)) dut_u (
		.clock(clock), .rst_n(rst_n), .supply_above_threshold(supply),
		.threshold_program(prog), .threshold_program_value(pval), .supply_reset_threshold(thr),
		.reset_low_in(low_lvl), .reset_low_out(low_out), .reset_low_oe(low_oe),
		.reset_high_in(high_lvl), .reset_high_out(high_out), .reset_high_oe(high_oe),
		.sda_in(sda), .write_protect(wp), .write_stop(stop), .bus_enable(bus_en),
		.write_busy(busy), .write_permit(permit), .write_commit(commit));
	// Variant without watchdog, its pins left released
	supply_supervisor_watchdog #(.POWER_UP_READ_CYCLES(PU), .WRITE_CYCLE_CYCLES(WC),
		.RESET_TIMEOUT_CYCLES(RT), .WATCHDOG_CYCLES(WD), .WATCHDOG_PRESENT(1'b0)) nowd_u (
		.clock(clock), .rst_n(rst_n), .supply_above_threshold(supply),
		.threshold_program(prog), .threshold_program_value(pval), .supply_reset_threshold(),
		.reset_low_in(1'b1), .reset_low_out(), .reset_low_oe(nowd_oe),
		.reset_high_in(1'b0), .reset_high_out(), .reset_high_oe(),
		.sda_in(sda), .write_protect(wp), .write_stop(stop), .bus_enable(),
		.write_busy(), .write_permit(), .write_commit());
	host_mcu_model mcu_u (.clock(clock), .kick_enable(kick), .force_low(f_low),
		.force_high(f_high), .reset_low_oe(low_oe), .reset_low_out(low_out),
		.reset_high_oe(high_oe), .reset_high_out(high_out), .sda(sda),
		.reset_low_level(low_lvl), .reset_high_level(high_lvl));

	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic threshold_type next_thr(input threshold_type cur, input threshold_type v);
		return (v < 3'h5) ? v : cur;
	endfunction
	task automatic cycles(input int k);
		repeat (k) @(negedge clock);
	endtask
	task automatic check_bit(input logic e, input logic g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic check_code(input threshold_type e, input threshold_type g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	// Waits for a level on a design output, bounded
	task automatic wait_for(ref logic s, input logic v, input int lim, output int k);
		k = 0;
		while (s !== v && k < lim) begin
			@(negedge clock);
			k++;
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		summarize();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		rst_n = 1'h0;
		{supply, prog, wp, stop, f_low, f_high} = 6'h0;
		kick = 1'h1;
		pval = 3'h0;
		exp_thr = 3'h0;
		seed = 16'h5e64;
		n_fail = 0;
		checked = 0;
		cycles(3);
		rst_n = 1'h1;
		cycles(10);
		check_bit(1'h0, low_lvl);
		check_bit(1'h1, high_lvl);
		check_bit(1'h0, bus_en);
		check_code(3'h0, thr);
		supply = 1'h1;
		wait_for(bus_en, 1'h1, 100, n);
		check_bit(1'h1, n >= PU && n <= PU + 6);
		wait_for(low_oe, 1'h0, 100, i);
		check_bit(1'h1, n + i >= RT && n + i <= RT + 8);
		check_bit(1'h0, high_oe);
		check_bit(1'h1, low_lvl);
		check_bit(1'h0, high_lvl);
		check_bit(1'h1, permit);
		stop = 1'h1;
		cycles(1);
		stop = 1'h0;
		wait_for(busy, 1'h1, 3, n);
		check_bit(1'h1, commit);
		check_bit(1'h0, bus_en);
		stop = 1'h1;
		cycles(1);
		stop = 1'h0;
		cycles(2);
		check_bit(1'h0, commit);
		wait_for(busy, 1'h0, 60, n);
		check_bit(1'h1, n >= WC - 8 && n <= WC + 1);
		cycles(2);
		check_bit(1'h1, bus_en);
		for (i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			wp = seed[0];
			pval = seed[3:1];
			prog = 1'h1;
			exp_thr = next_thr(exp_thr, pval);
			cycles(1);
			prog = 1'h0;
			cycles(4);
			check_code(exp_thr, thr);
			check_bit(~wp, permit);
			stop = 1'h1;
			cycles(1);
			stop = 1'h0;
			cycles(2);
			check_bit(~wp, busy);
			wait_for(busy, 1'h0, WC + 5, n);
			cycles(2);
		end
		wp = 1'h0;
		for (i = 0; i < 2; i++) begin
			cycles(5);
			f_low = (i == 0);
			f_high = (i == 1);
			cycles(10);
			{f_low, f_high} = 2'h0;
			cycles(8);
			check_bit(1'h0, low_oe);
			f_low = (i == 0);
			f_high = (i == 1);
			cycles(RT + 40);
			check_bit(1'h1, low_oe);
			check_bit(1'h1, high_oe);
			kick = (i == 0);
			{f_low, f_high} = 2'h0;
			wait_for(low_oe, 1'h0, RT + 20, n);
			check_bit(1'h1, n <= RT + 8);
		end
		wait_for(low_oe, 1'h1, WD + 20, n);
		check_bit(1'h1, n >= WD - 2 && n <= WD + 4);
		check_bit(1'h0, nowd_oe);
		kick = 1'h1;
		wait_for(low_oe, 1'h0, RT + 20, n);
		cycles(200);
		check_bit(1'h0, low_oe);
		supply = 1'h0;
		wait_for(low_oe, 1'h1, 10, n);
		check_bit(1'h1, n <= 5);
		check_bit(1'h1, high_oe);
		cycles(3);
		check_bit(1'h0, permit);
		check_bit(1'h0, bus_en);
		stop = 1'h1;
		cycles(1);
		stop = 1'h0;
		cycles(2);
		check_bit(1'h0, busy);
		summarize();
	end
endmodule
`default_nettype wire
